// file: include/mmu_subpage_abort_regs.vh
// Register offsets, fields, reset values, codes and counts of the subpage
// permission, external abort and enable-order unit.
// Assumes a byte-addressed Avalon-MM slave port with 32-bit data.
//
// How it works
// R01: Page access picks one of four quarter fields
// R02: Small page quarters are 1KB each
// R03: Large page quarters are 16KB each
// R04: Subpage bits decode as section; subpage fault
// R05: Abortable access stops the cycle after abort
// R06: Aborted locked read suppresses its write
// R07: Linefetch abort on any word purges line
// R08: Core aborted only on its requested word
// R09: Buffered writes are never externally aborted
// R10: Abortable memory mapped uncachable and unbufferable
// R11: Cache and buffer enabled only with translation; the code follows their bits with no interlock
// R12: Set translation bit after tables are built
// R13: Two fetches stay flat after enable change
// R14: Disable buffer, then cache, then translation
// R15: Translation buffer kept across disable and enable
// R16: Permission checked only for client domains
// R17: Manager domains bypass all permission checks
// R18: Linefetch abort records 0100/0110 and start address
// R19: Abort arrives with the faulting transfer's cycle
`ifndef MMU_SUBPAGE_ABORT_REGS_VH
`define MMU_SUBPAGE_ABORT_REGS_VH

`define OFS_CONTROL      5'h00
`define OFS_DOMAIN       5'h04
`define OFS_FAULT_STATUS 5'h08
`define OFS_FAULT_ADDR   5'h0C
`define OFS_TLB_FLUSH    5'h10

`define CTL_XLATE_BIT    0
`define CTL_ALIGN_BIT    1
`define CTL_CACHE_BIT    2
`define CTL_WBUF_BIT     3
`define CTL_SYS_BIT      8
`define CTL_ROM_BIT      9
`define CTL_RESET        10'h000
`define DOMAIN_RESET     32'h00000000

`define DOM_NONE         2'h0
`define DOM_CLIENT       2'h1
`define DOM_MANAGER      2'h3

`define FS_BUS_L1        4'hC
`define FS_BUS_L2        4'hE
`define FS_DOM_SECT      4'h9
`define FS_DOM_PAGE      4'hB
`define FS_PERM_SECT     4'hD
`define FS_PERM_SUB      4'hF
`define FS_LINE_SECT     4'h4
`define FS_LINE_PAGE     4'h6
`define FS_BUS_SECT      4'h8
`define FS_BUS_PAGE      4'hA

`define KIND_READ        3'h0
`define KIND_UNBUF_WR    3'h1
`define KIND_BUF_WR      3'h2
`define KIND_L1_FETCH    3'h3
`define KIND_L2_FETCH    3'h4
`define KIND_LOCK_RD     3'h5
`define KIND_LOCK_WR     3'h6
`define KIND_LINE        3'h7

`define SMALL_QTR_LSB    10
`define LARGE_QTR_LSB    14
`define FLAT_FETCHES     2'h2

`endif

// file: rtl/mmu_subpage_abort_enable_control.v
// Subpage permission check, external abort handling and enable sequencing.
// Assumes one clock; the core and the memory system present requests
// synchronous to mclk, with the abort input in the faulting word's cycle.
// Outputs are registered except the bus wait signal and the enable bits.
`include "mmu_subpage_abort_regs.vh"

module mmu_subpage_abort_enable_control #(
  parameter LINE_WORDS = 4,
  parameter WORD_BITS  = 2
) (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        chk_req,
  input  wire [31:0] chk_addr,
  input  wire        chk_page,
  input  wire        chk_large,
  input  wire [1:0]  chk_section_ap,
  input  wire [7:0]  chk_subpage_ap,
  input  wire [3:0]  chk_domain,
  input  wire        chk_write,
  input  wire        chk_user,
  input  wire        chk_data,
  output reg         chk_done,
  output reg         chk_fault,
  output reg  [3:0]  chk_fault_code,
  input  wire        ext_start,
  input  wire [2:0]  ext_kind,
  input  wire [31:0] ext_addr,
  input  wire        ext_page,
  input  wire [3:0]  ext_domain,
  input  wire        ext_data,
  input  wire [WORD_BITS-1:0] ext_req_word,
  input  wire        ext_word_done,
  input  wire        external_abort_input,
  output reg         ext_grant,
  output reg         ext_stop,
  output reg         core_abort,
  output reg         line_purge,
  output reg         ifetch_translate,
  input  wire        ifetch,
  output wire        translate_enable,
  output wire        unified_cache_enable,
  output wire        write_buffer_enable,
  output wire        align_check_enable,
  output reg         tlb_flush
);

  // ==========================================================================
  // Register file
  // ==========================================================================
  reg  [9:0]  ctrl_r;
  reg  [31:0] domain_r;
  reg  [3:0]  fs_code_r;
  reg  [3:0]  fs_domain_r;
  reg  [31:0] fault_addr_r;
  reg         rd_ack_r;
  reg  [31:0] rd_nxt;
  reg  [31:0] wmask;

  // Writes never stall, so every write strobe is taken
  wire wr_en = avs_write;

  // Reads take one wait state; writes complete with no wait
  assign avs_waitrequest = avs_read & ~rd_ack_r;

  always @* begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Read multiplexer; unmapped offsets read as zero
    if (avs_address == `OFS_CONTROL) begin
      rd_nxt = {22'h0, ctrl_r};
    end else if (avs_address == `OFS_DOMAIN) begin
      rd_nxt = domain_r;
    end else if (avs_address == `OFS_FAULT_STATUS) begin
      rd_nxt = {24'h000000, fs_domain_r, fs_code_r};
    end else if (avs_address == `OFS_FAULT_ADDR) begin
      rd_nxt = fault_addr_r;
    end else begin
      rd_nxt = 32'h00000000;
    end
  end

  // Control word after the byte-lane merge
  wire [31:0] ctrl_wr = ({22'h0, ctrl_r} & ~wmask) | (avs_writedata & wmask);

  // Cache and buffer follow their bits directly; no interlock with translation
  assign translate_enable     = ctrl_r[`CTL_XLATE_BIT];
  assign unified_cache_enable = ctrl_r[`CTL_CACHE_BIT];  // [R11]
  assign write_buffer_enable  = ctrl_r[`CTL_WBUF_BIT];   // [R11] [R14]
  assign align_check_enable   = ctrl_r[`CTL_ALIGN_BIT];

  // Register writes and the registered read path
  always @(posedge mclk) begin
    if (sys_rst) begin
      rd_ack_r     <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrl_r       <= `CTL_RESET;
      domain_r     <= `DOMAIN_RESET;
      tlb_flush    <= 1'b0;
    end else begin
      rd_ack_r  <= avs_read & ~rd_ack_r;
      tlb_flush <= 1'b0;
      if (avs_read & ~rd_ack_r) begin
        avs_readdata <= rd_nxt;
      end
      if (wr_en) begin
        if (avs_address == `OFS_CONTROL) begin
          ctrl_r <= ctrl_wr[9:0];
        end else if (avs_address == `OFS_DOMAIN) begin
          domain_r <= (domain_r & ~wmask) | (avs_writedata & wmask);
        end else if (avs_address == `OFS_TLB_FLUSH) begin
          // Only software empties the translation buffer [R15]
          tlb_flush <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Flat fetches after a translation enable change
  // ==========================================================================
  // A write that flips the translation bit restarts the flat count
  reg [1:0] flat_cnt_r;
  wire xlate_wr = wr_en && (avs_address == `OFS_CONTROL) &&
                  (ctrl_wr[`CTL_XLATE_BIT] != ctrl_r[`CTL_XLATE_BIT]);

  always @(posedge mclk) begin
    if (sys_rst) begin
      flat_cnt_r       <= 2'h0;
      ifetch_translate <= 1'b0;
    end else if (xlate_wr) begin
      flat_cnt_r <= `FLAT_FETCHES;  // [R13]
    end else if (flat_cnt_r != 2'h0) begin
      // Fetches during the count still use the old setting
      if (ifetch) begin
        flat_cnt_r <= flat_cnt_r - 2'h1;
      end
    end else begin
      // Third fetch onward sees the new setting
      ifetch_translate <= ctrl_r[`CTL_XLATE_BIT];  // [R13] [R12]
    end
  end

  // ==========================================================================
  // Domain and permission check
  // ==========================================================================
  reg  [1:0] sel_ap;
  reg  [1:0] qtr;
  reg        perm_ok;
  reg  [3:0] code_nxt;
  reg        fault_nxt;
  // Two access bits of the domain named by the request
  wire [1:0] dom_bits = domain_r[{chk_domain, 1'b0} +: 2];
  wire       s_bit    = ctrl_r[`CTL_SYS_BIT];
  wire       r_bit    = ctrl_r[`CTL_ROM_BIT];

  always @* begin
    // Quarter index from the address within a small or large page
    if (chk_large) begin
      qtr = chk_addr[`LARGE_QTR_LSB +: 2];  // [R03]
    end else begin
      qtr = chk_addr[`SMALL_QTR_LSB +: 2];  // [R02]
    end
    sel_ap = chk_subpage_ap[{qtr, 1'b0} +: 2];  // [R01]
    if (!chk_page) begin
      sel_ap = chk_section_ap;
    end
    // One decode serves sections and subpages alike [R04]
    case (sel_ap)
      2'h0: perm_ok = !chk_write && ((s_bit && !r_bit && !chk_user) ||
                                     (!s_bit && r_bit));
      2'h1: perm_ok = !chk_user;
      2'h2: perm_ok = !chk_user || !chk_write;
      default: perm_ok = 1'b1;
    endcase

    fault_nxt = 1'b0;
    code_nxt  = 4'h0;
    if (dom_bits == `DOM_CLIENT) begin
      if (!perm_ok) begin  // [R16]
        fault_nxt = 1'b1;
        code_nxt  = chk_page ? `FS_PERM_SUB : `FS_PERM_SECT;  // [R04]
      end
    end else if (dom_bits != `DOM_MANAGER) begin
      fault_nxt = 1'b1;
      code_nxt  = chk_page ? `FS_DOM_PAGE : `FS_DOM_SECT;
    end
    // Manager domain leaves fault_nxt clear [R17]
  end

  // ==========================================================================
  // External access tracking
  // ==========================================================================
  localparam ST_IDLE = 2'h0;
  localparam ST_XFER = 2'h1;
  localparam ST_LINE = 2'h2;

  reg [1:0]           state_r;
  reg [2:0]           kind_r;
  reg [31:0]          addr_r;
  reg                 page_r;
  reg [3:0]           dom_r;
  reg                 data_r;
  reg [WORD_BITS-1:0] req_word_r;
  reg [WORD_BITS-1:0] word_r;
  reg                 line_bad_r;
  reg                 lock_kill_r;

  localparam [31:0] LAST_IDX = LINE_WORDS - 1;
  wire [WORD_BITS-1:0] last_word = LAST_IDX[WORD_BITS-1:0];
  // Buffered writes are already complete for the core and cannot abort
  wire abort_now  = external_abort_input && (state_r != ST_IDLE) &&
                    (kind_r != `KIND_BUF_WR);  // [R09] [R19]
  // Write half of a locked pair whose read half failed
  wire start_kill = ext_start && (ext_kind == `KIND_LOCK_WR) && lock_kill_r;

  always @(posedge mclk) begin
    if (sys_rst) begin
      state_r      <= ST_IDLE;
      kind_r       <= `KIND_READ;
      addr_r       <= 32'h00000000;
      page_r       <= 1'b0;
      dom_r        <= 4'h0;
      data_r       <= 1'b0;
      req_word_r   <= {WORD_BITS{1'b0}};
      word_r       <= {WORD_BITS{1'b0}};
      line_bad_r   <= 1'b0;
      lock_kill_r  <= 1'b0;
      ext_grant    <= 1'b0;
      ext_stop     <= 1'b0;
      core_abort   <= 1'b0;
      line_purge   <= 1'b0;
      chk_done     <= 1'b0;
      chk_fault    <= 1'b0;
      chk_fault_code <= 4'h0;
      fs_code_r    <= 4'h0;
      fs_domain_r  <= 4'h0;
      fault_addr_r <= 32'h00000000;
    end else begin
      ext_grant  <= 1'b0;
      ext_stop   <= 1'b0;
      core_abort <= 1'b0;
      line_purge <= 1'b0;

      // Check answers one cycle after the request
      chk_done   <= chk_req;
      chk_fault  <= chk_req & fault_nxt;
      if (chk_req) begin
        chk_fault_code <= code_nxt;
      end
      // Fault record for data-side domain and permission faults
      if (chk_req && fault_nxt && chk_data) begin
        fs_code_r    <= code_nxt;
        fs_domain_r  <= chk_domain;
        fault_addr_r <= chk_addr;
      end

      // External access sequencing
      case (state_r)
        ST_IDLE: begin
          if (ext_start) begin
            kind_r     <= ext_kind;
            addr_r     <= ext_addr;
            page_r     <= ext_page;
            dom_r      <= ext_domain;
            data_r     <= ext_data;
            req_word_r <= ext_req_word;
            word_r     <= {WORD_BITS{1'b0}};
            line_bad_r <= 1'b0;
            if (ext_kind != `KIND_LOCK_WR) begin
              lock_kill_r <= 1'b0;
            end
            if (start_kill) begin
              // Write half of a failed locked pair never reaches the bus
              lock_kill_r <= 1'b0;  // [R06]
            end else begin
              ext_grant <= 1'b1;
              state_r   <= (ext_kind == `KIND_LINE) ? ST_LINE : ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (abort_now) begin
            ext_stop   <= 1'b1;  // [R05]
            core_abort <= 1'b1;
            state_r    <= ST_IDLE;
            if (kind_r == `KIND_LOCK_RD) begin
              lock_kill_r <= 1'b1;  // [R06]
            end
            // Only data-side aborts update the fault registers
            if (data_r) begin
              fault_addr_r <= addr_r;
              fs_domain_r  <= dom_r;
              if (kind_r == `KIND_L1_FETCH) begin
                fs_code_r <= `FS_BUS_L1;
              end else if (kind_r == `KIND_L2_FETCH) begin
                fs_code_r <= `FS_BUS_L2;
              end else begin
                fs_code_r <= page_r ? `FS_BUS_PAGE : `FS_BUS_SECT;
              end
            end
          end else if (ext_word_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_LINE: begin
          if (abort_now) begin
            line_bad_r <= 1'b1;  // [R07]
            if (word_r == req_word_r) begin
              core_abort <= 1'b1;  // [R08]
              if (data_r) begin
                fs_code_r    <= page_r ? `FS_LINE_PAGE : `FS_LINE_SECT;  // [R18]
                fs_domain_r  <= dom_r;
                fault_addr_r <= addr_r;  // [R18]
              end
            end
          end
          // Completion or abort both close the current word
          if (ext_word_done || abort_now) begin
            word_r <= word_r + {{(WORD_BITS-1){1'b0}}, 1'b1};
            if (word_r == last_word) begin
              // The whole line is drained, then dropped if any word failed
              line_purge <= line_bad_r | abort_now;  // [R07]
              state_r    <= ST_IDLE;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: test/mmu_sae_checker_assertions.sv
// Checker for the subpage permission, external abort and enable unit.
// Sees only the unit's ports; bound to every instance at the foot.
module mmu_sae_checker (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       chk_req,
  input wire logic       chk_done,
  input wire logic       chk_fault,
  input wire logic       ext_start,
  input wire logic [2:0] ext_kind,
  input wire logic       ext_word_done,
  input wire logic       external_abort_input,
  input wire logic       ext_stop,
  input wire logic       core_abort,
  input wire logic       line_purge,
  input wire logic       tlb_flush
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] kind_r;
  // ====
  // Kind of the access in flight
  always @(posedge mclk) begin
    if (sys_rst)
      kind_r <= 3'h0;
    else if (ext_start)
      kind_r <= ext_kind;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ====
  // Properties
  property p_chk; chk_req |=> chk_done; endproperty
  property p_flt; chk_fault |-> chk_done; endproperty
  property p_stop; external_abort_input && kind_r != 3'h7 && kind_r != 3'h2
    |=> ext_stop && core_abort; endproperty
  property p_stop_src; ext_stop |-> $past(external_abort_input); endproperty
  property p_line; external_abort_input && kind_r == 3'h7 |=> !ext_stop; endproperty
  property p_purge; line_purge |-> $past(ext_word_done || external_abort_input); endproperty
  property p_core; core_abort |-> $past(external_abort_input); endproperty
  property p_flush; avs_write && avs_address == 5'h10 |=> tlb_flush; endproperty
  property p_rd; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_chk: assert property (p_chk) else $error("check answer missing");
  a_flt: assert property (p_flt) else $error("fault without done");
  a_stop: assert property (p_stop) else $error("abort not stopped");
  a_stop_src: assert property (p_stop_src) else $error("stop without abort");
  a_line: assert property (p_line) else $error("linefetch stopped");
  a_purge: assert property (p_purge) else $error("purge without word");
  a_core: assert property (p_core) else $error("core abort without cause");
  a_flush: assert property (p_flush) else $error("flush pulse missing");
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  c_purge: cover property (line_purge);
  c_stop: cover property (ext_stop && core_abort);
  c_fault: cover property (chk_fault);
endmodule

bind mmu_subpage_abort_enable_control mmu_sae_checker chk_u (.mclk, .sys_rst, .avs_address,
  .avs_read, .avs_write, .avs_waitrequest, .chk_req, .chk_done, .chk_fault, .ext_start,
  .ext_kind, .ext_word_done, .external_abort_input, .ext_stop, .core_abort, .line_purge,
  .tlb_flush);

// file: test/ext_mem_model.sv
// Memory-side model: answers each granted external access word by word.
// Assumes the bench holds the access kind until the model goes idle.
module ext_mem_model #(
  parameter LINE_WORDS = 4
) (
  input  wire logic       mclk,
  input  wire logic       ext_grant,
  input  wire logic [2:0] ext_kind,
  input  wire logic [2:0] abort_at,
  input  wire logic       slow,
  output logic            ext_word_done,
  output logic            external_abort_input,
  output logic            mem_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n;
  logic hit;
  initial begin
    {ext_word_done, external_abort_input, mem_busy} = 3'h0;
  end
  always begin
    @(posedge mclk);
    if (ext_grant) begin
      mem_busy <= 1'b1;
      n = (ext_kind == 3'h7) ? LINE_WORDS : 1;
      for (int i = 0; i < n; i++) begin
        repeat (slow ? $urandom_range(2) : 0) begin
          {ext_word_done, external_abort_input} <= 2'b00;
          @(posedge mclk);
        end
        hit = (i == abort_at) && (ext_kind != 3'h2);
        // Abort replaces completion in the faulting word's cycle
        {ext_word_done, external_abort_input} <= {!hit, hit};
        @(posedge mclk);
        if (hit && ext_kind != 3'h7)
          break;
      end
      {ext_word_done, external_abort_input, mem_busy} <= 3'h0;
    end
  end
endmodule

// file: test/mmu_subpage_abort_enable_control_test.sv
// Bench: random permission checks, external aborts, enable ordering.
// Assumes ext_mem_model and the bound checker are compiled alongside.
module mmu_subpage_abort_enable_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest, ifetch, slow, mem_busy;
  logic        chk_req, chk_page, chk_large, chk_write, chk_user, chk_data, chk_done, chk_fault;
  logic        ext_start, ext_page, ext_data, ext_word_done, external_abort_input, ext_grant;
  logic        ext_stop, core_abort, line_purge, ifetch_translate, translate_enable;
  logic        unified_cache_enable, write_buffer_enable, align_check_enable, tlb_flush;
  logic [1:0]  chk_section_ap, ext_req_word;
  logic [2:0]  ext_kind, abort_at;
  logic [3:0]  avs_byteenable, chk_domain, chk_fault_code, ext_domain;
  logic [4:0]  avs_address;
  logic [7:0]  chk_subpage_ap;
  logic [31:0] avs_writedata, avs_readdata, chk_addr, ext_addr, dom_r, gcnt, fails, cmp_count;
  logic [63:0] exp_q[$];

  mmu_subpage_abort_enable_control dut_u (.mclk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .chk_req,
    .chk_addr, .chk_page, .chk_large, .chk_section_ap, .chk_subpage_ap, .chk_domain,
    .chk_write, .chk_user, .chk_data, .chk_done, .chk_fault, .chk_fault_code, .ext_start,
    .ext_kind, .ext_addr, .ext_page, .ext_domain, .ext_data, .ext_req_word, .ext_word_done,
    .external_abort_input, .ext_grant, .ext_stop, .core_abort, .line_purge, .ifetch_translate,
    .ifetch, .translate_enable, .unified_cache_enable, .write_buffer_enable,
    .align_check_enable, .tlb_flush);
  ext_mem_model mem_u (.mclk, .ext_grant, .ext_kind, .abort_at, .slow, .ext_word_done,
    .external_abort_input, .mem_busy);

  // ====
  // Comparison and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic push(input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({m, v});
  endtask
  task automatic take(input logic [31:0] seen);
    logic [63:0] e;
    e = (exp_q.size() == 0) ? {32'hFFFFFFFF, ~seen} : exp_q.pop_front();
    check(seen & e[63:32], e[31:0]);
  endtask
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    {avs_read, avs_write, avs_address, avs_writedata} <= {rd, !rd, a, d};
    do @(posedge mclk); while (avs_waitrequest);
    {avs_read, avs_write} <= 2'b00;
  endtask
  task automatic fetch();
    @(posedge mclk);
    ifetch <= 1'b1;
    @(posedge mclk);
    ifetch <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic flat(input logic v);
    check({31'h0, ifetch_translate}, {31'h0, !v});
    fetch();
    check({31'h0, ifetch_translate}, {31'h0, !v});
    fetch();
    check({31'h0, ifetch_translate}, {31'h0, v});
  endtask
  task automatic ext(input logic [2:0] k, input logic [2:0] ab, input logic [1:0] rq);
    logic [31:0] g0;
    g0 = gcnt;
    if (k != 3'h2 && k != 3'h6 && (ab == 3'h0 || k == 3'h7)) begin
      if (k != 3'h7 || ab[1:0] == rq)
        push(32'h3, 32'h2);
      if (k == 3'h7)
        push(32'h3, 32'h1);
    end
    {ext_kind, abort_at, ext_req_word, ext_start} <= {k, ab, rq, 1'b1};
    @(posedge mclk);
    ext_start <= 1'b0;
    repeat (2) @(posedge mclk);
    while (mem_busy) @(posedge mclk);
    repeat (3) @(posedge mclk);
    check(gcnt - g0, {31'h0, k != 3'h6});
  endtask
  function automatic logic [31:0] perm(input logic [31:0] r, input logic [31:0] a);
    logic [1:0] d, q, ap;
    logic       den;
    d = dom_r[2 * r[10:7] +: 2];
    q = r[2] ? a[15:14] : a[11:10];
    ap = r[3] ? r[11 + 2 * q +: 2] : r[1:0];
    den = ap == 2'h0 || (ap == 2'h1 && r[5]) || (ap == 2'h2 && r[5] && r[6]);
    if (!d[0])
      return r[3] ? 32'h1B : 32'h19;
    if (d == 2'h1 && den)
      return r[3] ? 32'h1F : 32'h1D;
    return 32'h0;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count != 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ====
  // Result monitor
  always @(posedge mclk) begin
    if (chk_done)
      take({27'h0, chk_fault, chk_fault_code});
    if (avs_read && !avs_waitrequest)
      take(avs_readdata);
    if (core_abort || line_purge)
      take({30'h0, core_abort, line_purge});
    if (ext_grant)
      gcnt++;
  end

  // ====
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    final_report();
  end
  initial begin
    logic [31:0] r, a;
    {avs_read, avs_write, avs_address, avs_writedata, chk_req, ifetch, ext_start} = '0;
    {chk_addr, chk_page, chk_large, chk_section_ap, chk_subpage_ap, chk_domain} = '0;
    {chk_write, chk_user, chk_data, ext_kind, ext_addr, ext_page, ext_req_word} = '0;
    {fails, cmp_count, gcnt, dom_r, abort_at, slow} = '0;
    {sys_rst, ext_data, avs_byteenable, ext_domain} = {2'b11, 4'hF, 4'h5};
    void'($urandom(57));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int t = 0; t < 3; t++) begin
      dom_r = $urandom;
      bus(1'b0, 5'h04, dom_r);
      for (int i = 0; i < 40; i++) begin
        r = $urandom;
        a = $urandom;
        @(posedge mclk);
        {chk_req, chk_addr, chk_page, chk_large, chk_section_ap} <= {1'b1, a, r[3:0]};
        {chk_subpage_ap, chk_domain, chk_write, chk_user, chk_data} <= r[18:4];
        push(32'h1F, perm(r, a));
      end
      @(posedge mclk);
      chk_req <= 1'b0;
    end
    $display("permission test done");
    for (int k = 0; k < 8; k++)
      ext(k[2:0], 3'h0, 2'h1);
    {slow, ext_page, ext_addr} <= {2'b11, 32'h00004A40};
    ext(3'h7, 3'h2, 2'h2);
    push(32'hF, 32'h6);
    bus(1'b1, 5'h08, 32'h0);
    push(32'hFFFFFFFF, 32'h00004A40);
    bus(1'b1, 5'h0C, 32'h0);
    push(32'hFFFFFFFF, 32'h0);
    bus(1'b1, 5'h14, 32'h0);
    bus(1'b0, 5'h10, 32'h0);
    $display("abort test done");
    bus(1'b0, 5'h00, 32'h0000000D);
    @(posedge mclk);
    check({28'h0, translate_enable, unified_cache_enable, write_buffer_enable,
           align_check_enable}, 32'hE);
    flat(1'b1);
    push(32'h30F, 32'hD);
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b0, 5'h00, 32'h0);
    @(posedge mclk);
    check({28'h0, translate_enable, unified_cache_enable, write_buffer_enable,
           align_check_enable}, 32'h0);
    flat(1'b0);
    check(32'(exp_q.size()), 32'h0);
    $display("enable test done");
    final_report();
  end
endmodule
